/* File: verilog/pifb_bank.sv */
// peripheral interrupt flag and enable bank with an axi4-lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ns
module pifb_bank (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [11:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [11:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic ADC_DONE_I,
  input wire logic RX_FULL_SET_I,
  input wire logic RX_DATA_READ_I,
  input wire logic TX_EMPTY_SET_I,
  input wire logic TX_DATA_WRITE_I,
  input wire logic SYNC_SERIAL_I,
  input wire logic [1:0] CCP_MODE_I,
  input wire logic TIMER1_CAPTURE_I,
  input wire logic TIMER1_COMPARE_I,
  input wire logic TIMER2_PERIOD_MATCH_I,
  input wire logic TIMER1_OVERFLOW_I,
  input wire logic OSC_FAIL_I,
  input wire logic CMP2_CHANGE_I,
  input wire logic CMP1_CHANGE_I,
  input wire logic EEWRITE_DONE_I,
  output logic [3:0] PIR2_EVENTS_O,
  output logic PERIPH_IRQ_O,
  output logic CORE_IRQ_O,
  output logic BUS_IRQ_O
);
  // ******************************************************
  // state
  // ******************************************************
  typedef struct packed {
    pifb_pkg::pifb_wr_t wr;
    pifb_pkg::pifb_rd_t rd;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] flags_1;
    logic [7:0] enables_1;
    logic [7:0] enables_2;
    logic [7:0] ctrl;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [3:0] pir2_ev;
    logic periph_irq;
    logic core_irq;
    logic bus_irq;
  } pifb_state_t;

  pifb_state_t st;
  pifb_state_t next_st;

  // address decode used by both the write and read paths
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == pifb_pkg::ADDR_FLAGS_1) || (a == pifb_pkg::ADDR_ENABLES_2) ||
      (a == pifb_pkg::ADDR_ENABLES_1) || (a == pifb_pkg::ADDR_CTRL) ||
      (a == pifb_pkg::ADDR_IRQ_STATUS) || (a == pifb_pkg::ADDR_IRQ_MASK);
  endfunction

  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  logic [7:0] pend_1;
  logic [3:0] pend_2;
  logic any_pend;
  logic wr_fire;
  logic rd_fire;
  logic [7:0] wbyte;
  logic [1:0] ev_set;
  logic [31:0] rd_word;

  // ******************************************************
  // next-state logic
  // ******************************************************
  always_comb begin
    next_st = st;
    wbyte = st.wdata[7:0];
    // flags set by hardware events or by software writes to the r/w flags, never by an enable
    flag_set = 8'h00;
    flag_set[6] = ADC_DONE_I;
    flag_set[5] = RX_FULL_SET_I;
    flag_set[4] = TX_EMPTY_SET_I;
    flag_set[3] = SYNC_SERIAL_I;
    flag_set[pifb_pkg::BIT_CAPCOMP] = ((CCP_MODE_I == pifb_pkg::CCP_CAPTURE) && TIMER1_CAPTURE_I) ||
      ((CCP_MODE_I == pifb_pkg::CCP_COMPARE) && TIMER1_COMPARE_I);
    flag_set[1] = TIMER2_PERIOD_MATCH_I;
    flag_set[0] = TIMER1_OVERFLOW_I;
    flag_clr = 8'h00;
    flag_clr[5] = RX_DATA_READ_I;
    flag_clr[4] = TX_DATA_WRITE_I;

    // write channel: address and data in either order
    if (S_AXI_AWVALID_I && st.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = S_AXI_AWADDR_I;
      next_st.awready = 1'b0;
    end
    if (S_AXI_WVALID_I && st.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = S_AXI_WDATA_I;
      next_st.wstrb = S_AXI_WSTRB_I;
      next_st.wready = 1'b0;
    end
    wr_fire = (st.wr == pifb_pkg::WR_IDLE) && st.aw_got && st.w_got;
    if (wr_fire) begin
      next_st.wr = pifb_pkg::WR_RESP;
      next_st.bvalid = 1'b1;
      next_st.bresp = addr_hit(st.awaddr) ? pifb_pkg::RESP_OKAY : pifb_pkg::RESP_SLVERR;
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      if (st.wstrb[0]) begin
        unique case (st.awaddr)
          pifb_pkg::ADDR_FLAGS_1: begin
            // software may write only the r/w flags; rx/tx ignore writes
            flag_clr = flag_clr | (pifb_pkg::FLAGS_1_SW & ~wbyte);
            flag_set = flag_set | (pifb_pkg::FLAGS_1_SW & wbyte);
          end
          pifb_pkg::ADDR_ENABLES_2: next_st.enables_2 = wbyte & pifb_pkg::ENABLES_2_IMPL;
          pifb_pkg::ADDR_ENABLES_1: next_st.enables_1 = wbyte & pifb_pkg::FLAGS_1_IMPL;
          pifb_pkg::ADDR_CTRL: next_st.ctrl = wbyte & pifb_pkg::CTRL_IMPL;
          pifb_pkg::ADDR_IRQ_MASK: next_st.irq_mask = wbyte[1:0] & pifb_pkg::IRQ_EV_IMPL;
          default: ;
        endcase
      end
    end
    if (st.wr == pifb_pkg::WR_RESP && S_AXI_BREADY_I) begin
      next_st.wr = pifb_pkg::WR_IDLE;
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    // event set wins over any clear in the same cycle
    next_st.flags_1 = ((st.flags_1 & ~flag_clr) | flag_set) & pifb_pkg::FLAGS_1_IMPL;
    next_st.pir2_ev = {OSC_FAIL_I, CMP2_CHANGE_I, CMP1_CHANGE_I, EEWRITE_DONE_I};

    // read channel
    rd_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR_I)
      pifb_pkg::ADDR_FLAGS_1: rd_word[7:0] = st.flags_1 & pifb_pkg::FLAGS_1_IMPL;
      pifb_pkg::ADDR_ENABLES_2: rd_word[7:0] = st.enables_2 & pifb_pkg::ENABLES_2_IMPL;
      pifb_pkg::ADDR_ENABLES_1: rd_word[7:0] = st.enables_1;
      pifb_pkg::ADDR_CTRL: rd_word[7:0] = st.ctrl;
      pifb_pkg::ADDR_IRQ_STATUS: rd_word[1:0] = st.irq_status;
      pifb_pkg::ADDR_IRQ_MASK: rd_word[1:0] = st.irq_mask;
      default: ;
    endcase
    rd_fire = S_AXI_ARVALID_I && st.arready;
    ev_set = 2'h0;
    if (rd_fire) begin
      next_st.rd = pifb_pkg::RD_DATA;
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = addr_hit(S_AXI_ARADDR_I) ? pifb_pkg::RESP_OKAY : pifb_pkg::RESP_SLVERR;
      if (S_AXI_ARADDR_I == pifb_pkg::ADDR_IRQ_STATUS) begin
        next_st.irq_status = 2'h0;
      end
    end
    if (st.rd == pifb_pkg::RD_DATA && S_AXI_RREADY_I) begin
      next_st.rd = pifb_pkg::RD_IDLE;
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // enable 1 passes a pending flag, 0 blocks it
    pend_1 = st.flags_1 & st.enables_1 & pifb_pkg::FLAGS_1_IMPL;
    pend_2 = st.pir2_ev & st.enables_2[7:4];
    any_pend = (|pend_1) || (|pend_2);
    // gate bit must be set for the periph and core forwards; global enable before core
    next_st.periph_irq = any_pend && st.ctrl[pifb_pkg::BIT_PERIPH_GATE];
    next_st.core_irq = any_pend && st.ctrl[pifb_pkg::BIT_PERIPH_GATE] && st.ctrl[pifb_pkg::BIT_GLOBAL_EN];

    // sticky bus status: set wins over the read-clear
    ev_set[0] = next_st.core_irq && !st.core_irq;
    ev_set[1] = |(flag_set & ~st.flags_1);
    next_st.irq_status = next_st.irq_status | ev_set;
    next_st.bus_irq = |(next_st.irq_status & next_st.irq_mask);

    if (!RSTN_I) begin
      next_st = '0;
      next_st.wr = pifb_pkg::WR_IDLE;
      next_st.rd = pifb_pkg::RD_IDLE;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
      next_st.flags_1 = pifb_pkg::RST_REG8;
      next_st.enables_2 = pifb_pkg::RST_REG8;
    end
  end

  // ******************************************************
  // registers
  // ******************************************************
  always_ff @(posedge CLK_SYS_I) begin
    st <= next_st;
  end

  assign S_AXI_AWREADY_O = st.awready;
  assign S_AXI_WREADY_O = st.wready;
  assign S_AXI_BRESP_O = st.bresp;
  assign S_AXI_BVALID_O = st.bvalid;
  assign S_AXI_ARREADY_O = st.arready;
  assign S_AXI_RDATA_O = st.rdata;
  assign S_AXI_RRESP_O = st.rresp;
  assign S_AXI_RVALID_O = st.rvalid;
  assign PIR2_EVENTS_O = st.pir2_ev;
  assign PERIPH_IRQ_O = st.periph_irq;
  assign CORE_IRQ_O = st.core_irq;
  assign BUS_IRQ_O = st.bus_irq;
endmodule

/* File: verilog/pifb_pkg.sv */
// package for the peripheral interrupt flag/enable bank
package pifb_pkg;
  // ******************************************************
  // register byte addresses (printed offsets are not all multiples of four)
  // ******************************************************
  localparam logic [7:0] IDX_FLAGS_1 = 8'h0c;
  localparam logic [7:0] IDX_ENABLES_2 = 8'h8d;
  localparam logic [7:0] IDX_ENABLES_1 = 8'h8c;
  localparam logic [7:0] IDX_CTRL = 8'h0b;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hf0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hf1;
  localparam logic [11:0] ADDR_FLAGS_1 = {2'h0, IDX_FLAGS_1, 2'h0};
  localparam logic [11:0] ADDR_ENABLES_2 = {2'h0, IDX_ENABLES_2, 2'h0};
  localparam logic [11:0] ADDR_ENABLES_1 = {2'h0, IDX_ENABLES_1, 2'h0};
  localparam logic [11:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  // ******************************************************
  // field positions and masks
  // ******************************************************
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_PERIPH_GATE = 6;
  localparam logic [7:0] FLAGS_1_IMPL = 8'h7f;
  localparam logic [7:0] FLAGS_1_SW = 8'h4f;
  localparam logic [7:0] ENABLES_2_IMPL = 8'hf0;
  localparam logic [7:0] CTRL_IMPL = 8'hc0;
  localparam logic [1:0] IRQ_EV_IMPL = 2'h3;
  localparam int BIT_CAPCOMP = 2;
  // ******************************************************
  // reset values and bus answers
  // ******************************************************
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // capture/compare unit mode
  localparam logic [1:0] CCP_CAPTURE = 2'h0;
  localparam logic [1:0] CCP_COMPARE = 2'h1;
  localparam logic [1:0] CCP_PWM = 2'h2;
  typedef enum logic [1:0] {WR_IDLE = 2'b00, WR_RESP = 2'b01} pifb_wr_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_DATA = 2'b01} pifb_rd_t;
endpackage

/* File: tb/pifb_periph.sv */
// peripheral side model: event pulses, capture/compare mode, held levels
`timescale 1ns/1ns
module pifb_periph (
  input wire logic clk_i,
  output logic [9:0] pulse_o,
  output logic [1:0] mode_o,
  output logic [3:0] level_o
);
  // ******************************
  // events
  // ******************************
  initial begin
    pulse_o = 10'h0;
    mode_o = 2'h0;
    level_o = 4'h0;
  end
  // mode moves with the pulse so the bank sees both at one edge
  task automatic fire(input int n, input logic [1:0] m);
    @(posedge clk_i);
    pulse_o[n] <= 1'b1;
    mode_o <= m;
    @(posedge clk_i);
    pulse_o <= 10'h0;
  endtask
  task automatic lvl(input logic [3:0] v);
    @(posedge clk_i);
    level_o <= v;
  endtask
endmodule

/* File: tb/pifb_bank_chk.sv */
// port checker for the flag/enable bank
`timescale 1ns/1ns
module pifb_bank_chk (
  input wire logic CLK_SYS_I, RSTN_I, S_AXI_AWVALID_I, S_AXI_AWREADY_O, S_AXI_WVALID_I, S_AXI_WREADY_O,
  input wire logic S_AXI_BVALID_O, S_AXI_BREADY_I, S_AXI_ARVALID_I, S_AXI_ARREADY_O, S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I, PERIPH_IRQ_O, CORE_IRQ_O, OSC_FAIL_I, CMP2_CHANGE_I, CMP1_CHANGE_I,
  input wire logic EEWRITE_DONE_I,
  input wire logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [3:0] PIR2_EVENTS_O
);
  // ******************************
  // assertions
  // ******************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  core_needs_gate_a: assert property (CORE_IRQ_O |-> PERIPH_IRQ_O) else $error("core irq without gate");
  pir2_follow_a: assert property ($past(RSTN_I) |-> PIR2_EVENTS_O == $past({OSC_FAIL_I, CMP2_CHANGE_I,
    CMP1_CHANGE_I, EEWRITE_DONE_I})) else $error("second flag levels wrong");
  rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read answer late");
  wr_answer_a: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
    |-> ##[1:2] S_AXI_BVALID_O) else $error("write answer late");
  b_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write answer dropped");
  r_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read answer dropped");
  upper_zero_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0)
    else $error("upper read bits set");
  err_data_a: assert property (S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2 |-> S_AXI_RDATA_O == 32'h0)
    else $error("error read with data");
  ar_busy_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O) else $error("read taken while busy");
  cover property (CORE_IRQ_O);
  cover property (PERIPH_IRQ_O && !CORE_IRQ_O);
  cover property (S_AXI_RVALID_O && S_AXI_RRESP_O == 2'h2);
endmodule
bind pifb_bank pifb_bank_chk chk_u (.*);

/* File: tb/pifb_bank_bench.sv */
// self-checking bench for the flag/enable bank
`timescale 1ns/1ns
module pifb_bank_bench;
  // ******************************
  // signals and instances
  // ******************************
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, periph, core, busirq;
  logic [1:0] bresp, rresp, mode;
  logic [31:0] rdata;
  logic [3:0] ev2, lv;
  logic [9:0] p;
  logic [33:0] exp_q[$], msk_q[$];
  logic [7:0] v, e;
  int err_count = 0, n_checks = 0, cycles = 0;
  always #20 clk = ~clk;
  pifb_periph periph_u (.clk_i(clk), .pulse_o(p), .mode_o(mode), .level_o(lv));
  pifb_bank dut_u (.CLK_SYS_I(clk), .RSTN_I(rstn), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'h1), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .ADC_DONE_I(p[6]),
    .RX_FULL_SET_I(p[5]), .RX_DATA_READ_I(p[8]), .TX_EMPTY_SET_I(p[4]), .TX_DATA_WRITE_I(p[9]),
    .SYNC_SERIAL_I(p[3]), .CCP_MODE_I(mode), .TIMER1_CAPTURE_I(p[2]), .TIMER1_COMPARE_I(p[7]),
    .TIMER2_PERIOD_MATCH_I(p[1]), .TIMER1_OVERFLOW_I(p[0]), .OSC_FAIL_I(lv[3]), .CMP2_CHANGE_I(lv[2]),
    .CMP1_CHANGE_I(lv[1]), .EEWRITE_DONE_I(lv[0]), .PIR2_EVENTS_O(ev2), .PERIPH_IRQ_O(periph),
    .CORE_IRQ_O(core), .BUS_IRQ_O(busirq));
  // ******************************
  // tasks
  // ******************************
  task automatic check(input logic [33:0] s, input logic [33:0] x);
    n_checks++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // address and data are held until each channel's own ready
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = pifb_pkg::RESP_OKAY);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(posedge clk); while (bvalid !== 1'b1);
    check({32'h0, bresp}, {32'h0, r});
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m,
    input logic [1:0] r = pifb_pkg::RESP_OKAY);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back({r, 24'h0, x});
    msk_q.push_back({26'h3ffffff, m});
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // outputs are registered: three edges cover the two-edge delay
  task automatic pins(input logic [2:0] x);
    repeat (3) @(posedge clk);
    #1;
    check({31'h0, busirq, core, periph}, {31'h0, x});
  endtask
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready) begin
      check({rresp, rdata} & msk_q[0], exp_q[0] & msk_q[0]);
      exp_q.delete(0);
      msk_q.delete(0);
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      summarize();
    end
  end
  // ******************************
  // scenarios
  // ******************************
  initial begin
    void'($urandom(32'hd9727ca7));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(pifb_pkg::ADDR_FLAGS_1, 8'h00, 8'hff);
    rd(pifb_pkg::ADDR_ENABLES_2, 8'h00, 8'hff);
    v = 8'($urandom);
    wr(pifb_pkg::ADDR_ENABLES_2, v);
    rd(pifb_pkg::ADDR_ENABLES_2, v & 8'hf0, 8'hff);
    wr(pifb_pkg::ADDR_FLAGS_1, 8'hff);
    rd(pifb_pkg::ADDR_FLAGS_1, 8'h4f, 8'hff);
    wr(pifb_pkg::ADDR_FLAGS_1, 8'h00);
    e = 8'h00;
    for (int n = 0; n < 7; n++) begin
      periph_u.fire(n, 2'h0);
      e[n] = 1'b1;
      rd(pifb_pkg::ADDR_FLAGS_1, e, 8'hff);
    end
    periph_u.fire(8, 2'h0);
    periph_u.fire(9, 2'h0);
    rd(pifb_pkg::ADDR_FLAGS_1, 8'h4f, 8'hff);
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 2; k++) begin
        wr(pifb_pkg::ADDR_FLAGS_1, 8'h00);
        periph_u.fire(k ? 7 : 2, m[1:0]);
        rd(pifb_pkg::ADDR_FLAGS_1, {5'h0, m == k, 2'h0}, 8'hff);
      end
    end
    periph_u.fire(6, 2'h0);
    wr(pifb_pkg::ADDR_ENABLES_1, 8'h40);
    pins(3'b000);
    wr(pifb_pkg::ADDR_CTRL, 8'h40);
    pins(3'b001);
    wr(pifb_pkg::ADDR_CTRL, 8'hc0);
    pins(3'b011);
    wr(pifb_pkg::ADDR_ENABLES_1, 8'h00);
    pins(3'b000);
    periph_u.lvl(4'h8);
    wr(pifb_pkg::ADDR_ENABLES_2, 8'h80);
    pins(3'b011);
    check({30'h0, ev2}, 34'h8);
    wr(pifb_pkg::ADDR_ENABLES_2, 8'h40);
    pins(3'b000);
    rd(pifb_pkg::ADDR_IRQ_STATUS, 8'h00, 8'h00);
    wr(pifb_pkg::ADDR_IRQ_MASK, 8'h02);
    pins(3'b000);
    periph_u.fire(0, 2'h0);
    pins(3'b100);
    rd(pifb_pkg::ADDR_IRQ_STATUS, 8'h02, 8'h02);
    pins(3'b000);
    wr(12'h3fc, 8'h55, pifb_pkg::RESP_SLVERR);
    rd(12'h3fc, 8'h00, 8'hff, pifb_pkg::RESP_SLVERR);
    summarize();
  end
endmodule
